// >>> shared/tpc_defs.svh
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
// Register addresses on the plain port, one address per whole register
`define TPC_ADDR_MODE 4'h0
`define TPC_ADDR_IOCTL 4'h1
`define TPC_ADDR_GRB 4'h2
`define TPC_ADDR_GRD 4'h3
`define TPC_ADDR_IRQ_STAT 4'h4
`define TPC_ADDR_IRQ_MASK 4'h5
`define TPC_ADDR_CH1_CTRL 4'h6
// Mode register fields
`define TPC_MODE_BFB 5
`define TPC_MODE_BFA 4
`define TPC_MODE_RESET 8'hC0
`define TPC_MODE_RO_MASK 8'hC0
`define TPC_MODE_WR_MASK 8'h3F
// I/O control field bits
`define TPC_IO_INPUT 3
`define TPC_IO_CH1 2
`define TPC_IO_INIT 2
// Status bits
`define TPC_ST_CAP 0
`define TPC_ST_CMP 1
// Prescaler code for undivided clock
`define TPC_PSC_UNDIV 3'h0
`endif

// >>> shared/tpc_pkg.sv
package tpc_pkg;
  typedef enum logic [1:0] {
    TPC_PIN_OFF,
    TPC_PIN_OUT,
    TPC_PIN_CAP,
    TPC_PIN_CH1
  } tpc_io_kind_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [3:0] ioctl;
    logic [15:0] grb;
    logic [15:0] grd;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [2:0] ch1_psc;
    logic pin_level;
    logic pin_prev;
    logic [15:0] rdata;
  } tpc_state_t;
endpackage

// >>> verilog/tpc_ch0.sv
`timescale 1ns/100ps
`include "tpc_defs.svh"
module tpc_ch0 #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Counter and channel 1 inputs
  input wire logic [CNT_W-1:0] counter_i,
  input wire logic ch1_count_i,
  input wire logic [CNT_W-1:0] compare_cnt_i,
  // Channel pin
  input wire logic pin_b_i,
  output logic pin_b_o,
  output logic pin_b_oe_n_o,
  // Mode outputs
  output logic [3:0] mode_sel_o,
  output logic buf_a_en_o,
  output logic reg_c_events_en_o,
  // Interrupt
  output logic irq_o
);
  tpc_pkg::tpc_state_t st_ff;
  tpc_pkg::tpc_state_t nxt_st;
  tpc_pkg::tpc_io_kind_t io_kind;
  logic match;
  logic rise;
  logic fall;
  logic cap_evt;
  logic cmp_evt;
  logic wr_stat;

  always_comb begin
    if (st_ff.ioctl[`TPC_IO_INPUT]) begin
      io_kind = st_ff.ioctl[`TPC_IO_CH1] ? tpc_pkg::TPC_PIN_CH1
                                         : tpc_pkg::TPC_PIN_CAP;
    end else if (st_ff.ioctl[1:0] == 2'h0) begin
      io_kind = tpc_pkg::TPC_PIN_OFF;
    end else begin
      io_kind = tpc_pkg::TPC_PIN_OUT;
    end
  end

  assign match = (counter_i == st_ff.grb);
  assign rise = pin_b_i & ~st_ff.pin_prev;
  assign fall = ~pin_b_i & st_ff.pin_prev;

  always_comb begin
    cap_evt = 1'b0;
    unique case (io_kind)
      tpc_pkg::TPC_PIN_CAP: begin
        unique case (st_ff.ioctl[1:0])
          2'h0: cap_evt = rise;
          2'h1: cap_evt = fall;
          default: cap_evt = rise | fall;
        endcase
      end
      tpc_pkg::TPC_PIN_CH1: begin
        cap_evt = ch1_count_i &
                  (st_ff.ch1_psc != `TPC_PSC_UNDIV);
      end
      tpc_pkg::TPC_PIN_OFF: cap_evt = 1'b0;
      tpc_pkg::TPC_PIN_OUT: cap_evt = 1'b0;
    endcase
  end

  assign cmp_evt = (io_kind == tpc_pkg::TPC_PIN_OUT) & match;
  assign wr_stat = reg_wr_i & (reg_addr_i == `TPC_ADDR_IRQ_STAT);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_prev = pin_b_i;
    nxt_st.rdata = 16'h0000;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `TPC_ADDR_MODE: begin
          nxt_st.mode = (reg_wdata_i[7:0] & `TPC_MODE_WR_MASK) |
                        `TPC_MODE_RO_MASK;
        end
        `TPC_ADDR_IOCTL: begin
          nxt_st.ioctl = reg_wdata_i[3:0];
          if (!reg_wdata_i[`TPC_IO_INPUT]) begin
            nxt_st.pin_level = reg_wdata_i[`TPC_IO_INIT];
          end
        end
        `TPC_ADDR_GRB: begin
          if (st_ff.mode[`TPC_MODE_BFB]) begin
            nxt_st.grd = reg_wdata_i;
          end
          nxt_st.grb = reg_wdata_i;
        end
        `TPC_ADDR_GRD: nxt_st.grd = reg_wdata_i;
        `TPC_ADDR_IRQ_MASK: nxt_st.irq_mask = reg_wdata_i[1:0];
        `TPC_ADDR_CH1_CTRL: nxt_st.ch1_psc = reg_wdata_i[2:0];
        default: ;
      endcase
    end
    if (wr_stat) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~reg_wdata_i[1:0];
    end
    if (cmp_evt) begin
      unique case (st_ff.ioctl[1:0])
        2'h1: nxt_st.pin_level = 1'b0;
        2'h2: nxt_st.pin_level = 1'b1;
        default: nxt_st.pin_level = ~st_ff.pin_level;
      endcase
      if (st_ff.mode[`TPC_MODE_BFB]) begin
        nxt_st.grb = st_ff.grd;
      end
      nxt_st.irq_stat[`TPC_ST_CMP] = 1'b1;
    end
    if (cap_evt) begin
      nxt_st.grb = counter_i;
      if (st_ff.mode[`TPC_MODE_BFB]) begin
        nxt_st.grd = st_ff.grb;
      end
      nxt_st.irq_stat[`TPC_ST_CAP] = 1'b1;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `TPC_ADDR_MODE: nxt_st.rdata = {8'h00, st_ff.mode};
        `TPC_ADDR_IOCTL: nxt_st.rdata = {12'h000, st_ff.ioctl};
        `TPC_ADDR_GRB: nxt_st.rdata = st_ff.grb;
        `TPC_ADDR_GRD: nxt_st.rdata = st_ff.grd;
        `TPC_ADDR_IRQ_STAT: nxt_st.rdata = {14'h0000, st_ff.irq_stat};
        `TPC_ADDR_IRQ_MASK: nxt_st.rdata = {14'h0000, st_ff.irq_mask};
        `TPC_ADDR_CH1_CTRL: nxt_st.rdata = {13'h0000, st_ff.ch1_psc};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.mode <= `TPC_MODE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;
  assign pin_b_o = st_ff.pin_level;
  assign pin_b_oe_n_o = (io_kind != tpc_pkg::TPC_PIN_OUT);
  assign mode_sel_o = st_ff.mode[3:0];
  assign buf_a_en_o = st_ff.mode[`TPC_MODE_BFA];
  assign reg_c_events_en_o = ~st_ff.mode[`TPC_MODE_BFA];
  assign irq_o = |(st_ff.irq_stat & st_ff.irq_mask);

  AST_MODE_TOP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) st_ff.mode[7:6] == 2'h3)
    else $error("Mode top bits not one");
  AST_MODE_WR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> st_ff.mode[5:0] == $past(reg_wdata_i[5:0]))
    else $error("Mode write lost");
  AST_MODE_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !(reg_wr_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> $stable(st_ff.mode)) else $error("Mode moved");
  AST_MODE_OUT: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> mode_sel_o == $past(reg_wdata_i[3:0]))
    else $error("Mode out");
  AST_MODE_SEL_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !(reg_wr_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> $stable(mode_sel_o)) else $error("Mode select moved");
  AST_BUFA_OUT: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> buf_a_en_o == $past(reg_wdata_i[`TPC_MODE_BFA]))
    else $error("Buffer A enable wrong");
  AST_C_NO_EVT: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_MODE &&
    reg_wdata_i[`TPC_MODE_BFA]) |=> !reg_c_events_en_o)
    else $error("C events on");
  AST_C_EVT_ON: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_MODE &&
    !reg_wdata_i[`TPC_MODE_BFA]) |=> reg_c_events_en_o)
    else $error("C events off");
  AST_OE_OFF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (!st_ff.ioctl[3] && st_ff.ioctl[1:0] == 2'h0)
    |-> pin_b_oe_n_o) else $error("Disabled pin driven");
  AST_OE_OUT: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (!st_ff.ioctl[3] && st_ff.ioctl[1:0] != 2'h0)
    |-> !pin_b_oe_n_o) else $error("Output pin not driven");
  AST_OE_IN: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) st_ff.ioctl[3] |-> pin_b_oe_n_o)
    else $error("Input pin driven");
  AST_IOCTL_WR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_wr_i && reg_addr_i == `TPC_ADDR_IOCTL)
    |=> st_ff.ioctl == $past(reg_wdata_i[3:0]))
    else $error("Control write lost");
  AST_SET_ONE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (cmp_evt && st_ff.ioctl[1:0] == 2'h2)
    |=> pin_b_o) else $error("Match did not drive one");
  AST_SET_ZERO: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (cmp_evt && st_ff.ioctl[1:0] == 2'h1)
    |=> !pin_b_o) else $error("Match did not drive zero");
  AST_TOGGLE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (cmp_evt && st_ff.ioctl[1:0] == 2'h3 && !reg_wr_i)
    |=> pin_b_o != $past(pin_b_o)) else $error("No toggle");
  AST_PIN_HOLD: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !cmp_evt &&
    !(reg_wr_i && reg_addr_i == `TPC_ADDR_IOCTL) |=> $stable(pin_b_o))
    else $error("Pin moved without match");
  AST_INIT_LVL: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) reg_wr_i && !cmp_evt &&
    reg_addr_i == `TPC_ADDR_IOCTL && !reg_wdata_i[3]
    |=> pin_b_o == $past(reg_wdata_i[2])) else $error("Init level");
  AST_CAP_KEEP_LVL: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) reg_wr_i && !cmp_evt &&
    reg_addr_i == `TPC_ADDR_IOCTL && reg_wdata_i[3] |=> $stable(pin_b_o))
    else $error("Capture code moved pin level");
  AST_CMP_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cmp_evt |=> st_ff.irq_stat[`TPC_ST_CMP])
    else $error("Compare flag not set");
  AST_NO_CMP_OFF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind != tpc_pkg::TPC_PIN_OUT && !wr_stat
    |=> $stable(st_ff.irq_stat[`TPC_ST_CMP]))
    else $error("Compare outside output code");
  AST_RISE_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CAP && rise &&
    st_ff.ioctl[1:0] == 2'h0 |=> st_ff.grb == $past(counter_i))
    else $error("No rise capture");
  AST_FALL_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CAP && fall &&
    st_ff.ioctl[1:0] == 2'h1 |=> st_ff.grb == $past(counter_i))
    else $error("No fall capture");
  AST_BOTH_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CAP && (rise || fall)
    && st_ff.ioctl[1] |=> st_ff.grb == $past(counter_i))
    else $error("No both edge capture");
  AST_RISE_ONLY: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CAP && !rise &&
    st_ff.ioctl[1:0] == 2'h0 |-> !cap_evt)
    else $error("Capture without rise");
  AST_CAP_FLAG: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cap_evt |=> st_ff.irq_stat[`TPC_ST_CAP])
    else $error("Capture flag not set");
  AST_CH1_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CH1 &&
    st_ff.ch1_psc != 3'h0 && ch1_count_i |=> st_ff.irq_stat[0])
    else $error("No channel 1 capture");
  AST_CH1_ANY: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) st_ff.ioctl[3:2] == 2'h3 && ch1_count_i &&
    st_ff.ch1_psc != 3'h0 |=> st_ff.grb == $past(counter_i))
    else $error("Channel 1 count not captured");
  AST_CH1_IDLE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CH1 && !ch1_count_i
    |-> !cap_evt) else $error("Capture without count step");
  AST_CH1_UNDIV: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CH1 &&
    st_ff.ch1_psc == 3'h0 |-> !cap_evt) else $error("Undivided capture");
  AST_CH1_UNDIV_B: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CH1 &&
    st_ff.ch1_psc == 3'h0 && !(reg_wr_i && reg_addr_i == `TPC_ADDR_GRB)
    |=> $stable(st_ff.grb)) else $error("Undivided B moved");
  AST_CH1_FLAG_NONE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) io_kind == tpc_pkg::TPC_PIN_CH1 &&
    st_ff.ch1_psc == 3'h0 && !wr_stat |=> $stable(st_ff.irq_stat[0]))
    else $error("Undivided capture flag");
  AST_BUF_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cap_evt && st_ff.mode[`TPC_MODE_BFB]
    |=> st_ff.grd == $past(st_ff.grb)) else $error("Buffer not loaded");
  AST_BUF_CMP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cmp_evt && st_ff.mode[`TPC_MODE_BFB]
    |=> st_ff.grb == $past(st_ff.grd)) else $error("B not reloaded");
  AST_BUF_WR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) reg_wr_i && reg_addr_i == `TPC_ADDR_GRB &&
    st_ff.mode[`TPC_MODE_BFB] && !cap_evt
    |=> st_ff.grd == $past(reg_wdata_i)) else $error("Buffer write lost");
  AST_GRD_ONLY_BUF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) st_ff.mode[`TPC_MODE_BFB] && !cap_evt &&
    !(reg_wr_i && reg_addr_i inside {`TPC_ADDR_GRB, `TPC_ADDR_GRD})
    |=> $stable(st_ff.grd)) else $error("D moved outside buffer");
  AST_NOBUF: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !st_ff.mode[`TPC_MODE_BFB] &&
    !(reg_wr_i && reg_addr_i == `TPC_ADDR_GRD) |=> $stable(st_ff.grd))
    else $error("D moved unbuffered");
  AST_NOBUF_CMP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cmp_evt && !st_ff.mode[`TPC_MODE_BFB] &&
    !(reg_wr_i && reg_addr_i == `TPC_ADDR_GRB) |=> $stable(st_ff.grb))
    else $error("B moved at unbuffered match");
  AST_NOBUF_WR: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) reg_wr_i && reg_addr_i == `TPC_ADDR_GRB && !cap_evt
    && !st_ff.mode[`TPC_MODE_BFB] |=> st_ff.grb == $past(reg_wdata_i))
    else $error("B write lost");
  AST_NOBUF_CAP: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cap_evt && !st_ff.mode[`TPC_MODE_BFB]
    |=> st_ff.grb == $past(counter_i)) else $error("Plain capture lost");
  AST_RD_GRB: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_rd_i && reg_addr_i == `TPC_ADDR_GRB)
    |=> reg_rdata_o == $past(st_ff.grb))
    else $error("B read wrong");
  AST_RD_MODE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) (reg_rd_i && reg_addr_i == `TPC_ADDR_MODE)
    |=> reg_rdata_o[7:6] == 2'h3)
    else $error("Mode top bits read zero");
  AST_RD_IDLE: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) !reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("Read data outside its cycle");
  AST_W1C: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wr_stat && !cap_evt && !cmp_evt
    |=> (st_ff.irq_stat & $past(reg_wdata_i[1:0])) == 2'h0)
    else $error("Status not cleared");
  AST_SET_WINS: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) wr_stat && cmp_evt |=> st_ff.irq_stat[`TPC_ST_CMP])
    else $error("Clear beat set");
  AST_IRQ_SET: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) cmp_evt && st_ff.irq_mask[`TPC_ST_CMP] |=> irq_o)
    else $error("Interrupt not raised");
endmodule // tpc_ch0

// >>> tb/tpc_pin_model.sv
`timescale 1ns/100ps
module tpc_pin_model (
  // Pin lines
  input wire logic pin_b_o,
  input wire logic pin_b_oe_n_o,
  input wire logic ext_level_i,
  output logic pin_b_i
);
  // Block level while it drives, outside source otherwise
  assign pin_b_i = pin_b_oe_n_o ? ext_level_i : pin_b_o;
endmodule // tpc_pin_model

// >>> tb/test_timer_ch0_mode_and_io_control.sv
`timescale 1ns/100ps
module test_timer_ch0_mode_and_io_control;
  logic ref_clk_i = 0, rst_n_i = 0, wr = 0, rd = 0, ch1 = 0, lvl = 0;
  logic [3:0] addr = 0, msel;
  logic [15:0] wd = 0, cnt = 0, rdata, rdat, g, h;
  logic pin_i, pin_o, oe_n, buf_a, c_en, irq;
  int failures = 0, check_count = 0, c;
  tpc_ch0 tpc_ch0_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .counter_i(cnt), .ch1_count_i(ch1),
    .compare_cnt_i(16'h0000), .pin_b_i(pin_i), .pin_b_o(pin_o),
    .pin_b_oe_n_o(oe_n), .mode_sel_o(msel), .buf_a_en_o(buf_a),
    .reg_c_events_en_o(c_en), .irq_o(irq));
  tpc_pin_model tpc_pin_model_i (.pin_b_o(pin_o), .pin_b_oe_n_o(oe_n),
    .ext_level_i(lvl), .pin_b_i(pin_i));
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task rdr(input logic [3:0] a);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1 rdat = rdata;
  endtask
  task settle;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask
  task match(input logic [15:0] v);
    @(posedge ref_clk_i);
    cnt <= v;
    @(posedge ref_clk_i);
    cnt <= 16'h0000;
    settle;
  endtask
  task step(input logic [15:0] v, input logic l, input logic s);
    @(posedge ref_clk_i);
    cnt <= v;
    lvl <= l;
    ch1 <= s;
    @(posedge ref_clk_i);
    ch1 <= 1'b0;
    settle;
    rdr(4'h2);
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    give_verdict;
  end
  initial begin
    void'($urandom(94870));
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rdr(4'h0); chk(rdat, 16'h00C0);
    repeat (6) begin
      h = 16'($urandom) & 16'h0037;
      wrr(4'h0, h);
      rdr(4'h0); chk(rdat, h | 16'h00C0);
      chk(16'(msel), 16'(h[3:0]));
      chk(16'(buf_a), 16'(h[4]));
      chk(16'(c_en), 16'(!h[4]));
    end
    rdr(4'h7); chk(rdat, 16'h0000);
    wrr(4'h0, 16'h0000);
    $display("test mode done");
    for (c = 0; c < 8; c++) begin
      g = 16'($urandom) | 16'h0001;
      wrr(4'h2, g);
      wrr(4'h1, 16'(c));
      settle;
      chk(16'(oe_n), 16'(c[1:0] == 2'b00));
      if (c[1:0] != 0) chk(16'(pin_o), 16'(c[2]));
      match(g);
      if (c[1:0] != 0) chk(16'(pin_o), 16'(c[1:0] == 3 ? !c[2] : c[1]));
    end
    rdr(4'h4); chk(rdat & 16'h0002, 16'h0002);
    chk(16'(irq), 16'h0000);
    wrr(4'h5, 16'h0002); settle; chk(16'(irq), 16'h0001);
    wrr(4'h4, 16'h0002); settle; chk(16'(irq), 16'h0000);
    $display("test compare done");
    for (c = 8; c < 11; c++) begin
      wrr(4'h1, 16'(c));
      wrr(4'h2, 16'h0000);
      g = 16'($urandom);
      h = 16'($urandom);
      step(g, 1'b1, 1'b0); chk(rdat, c == 9 ? 16'h0000 : g);
      step(h, 1'b0, 1'b0); chk(rdat, c == 8 ? g : h);
    end
    wrr(4'h1, 16'(12 + $urandom_range(3)));
    wrr(4'h6, 16'($urandom_range(7, 1)));
    step(g, 1'b0, 1'b1); chk(rdat, g);
    wrr(4'h6, 16'h0000);
    step(h, 1'b0, 1'b1); chk(rdat, g);
    $display("test capture done");
    wrr(4'h1, 16'h0001);
    wrr(4'h0, 16'h0020);
    wrr(4'h2, g);
    wrr(4'h3, ~g);
    match(g);
    rdr(4'h2); chk(rdat, ~g);
    wrr(4'h0, 16'h0000);
    wrr(4'h2, g);
    wrr(4'h3, ~g);
    match(g);
    rdr(4'h2); chk(rdat, g);
    $display("test buffer done");
    give_verdict;
  end
endmodule // test_timer_ch0_mode_and_io_control
